// ===== logic/status_pkg.sv
/*
 * constants, command codes and preset values of the status reporting block.
 * assumes a single system clock; no module lives here.
 */
package status_pkg;

    // status byte bit positions
    localparam int SBYTE_BIT_ERRQ = 2;
    localparam int SBYTE_BIT_QUES = 3;
    localparam int SBYTE_BIT_MAV = 4;
    localparam int SBYTE_BIT_ESB = 5;
    localparam int SBYTE_BIT_MSS = 6;
    localparam int SBYTE_BIT_OPER = 7;

    // register groups reached through the group select
    localparam int GRP_QUES = 0;
    localparam int GRP_OPER = 1;
    localparam int NUM_GROUPS = 2;

    // group register width and preset / reset values
    localparam int GROUP_WIDTH = 16;
    localparam logic [15:0] ENAB_PRESET = 16'h0000;
    localparam logic [15:0] RISE_PRESET = 16'hffff;
    localparam logic [15:0] FALL_PRESET = 16'h0000;
    localparam logic [15:0] EVENT_CLEAR = 16'h0000;
    localparam logic [7:0] MASK8_RESET = 8'h00;
    localparam logic [7:0] SBYTE_RESET = 8'h00;

    // width of the decoded command code port
    localparam int CMD_OP_WIDTH = 5;

    // decoded host commands
    typedef enum logic [4:0] {
        OP_SRMASK_WR,
        OP_SRMASK_RD,
        OP_SBYTE_RD,
        OP_POLL,
        OP_SEMASK_WR,
        OP_SEMASK_RD,
        OP_ESR_RD,
        OP_CLRST,
        OP_PRESET,
        OP_EVEN_RD,
        OP_COND_RD,
        OP_ENAB_WR,
        OP_ENAB_RD,
        OP_RISE_WR,
        OP_RISE_RD,
        OP_FALL_WR,
        OP_FALL_RD
    } cmd_op_t;

endpackage

// ===== logic/status_reporting_model.sv
/*
 * status reporting model: two register groups (questionable, operation), a
 * standard event register, the summary status byte and the service request.
 * assumes a command parser on the same clock delivers decoded commands one
 * per cycle, and that condition inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - writable service request mask selects status byte bits into summary bit 6
// - any masked status bit going zero to one raises the service request
// - reading the service request mask returns the enabled bits
// - status byte query equals serial poll but leaves the request standing
// - condition registers follow live state, read-only, reads clear nothing
// - event bits latch; more events on a set bit are dropped
// - event bit holds until its group's event read, clear-status or preset
// - group enable mask picks event bits feeding the group summary
// - clear-status clears all event registers, keeps every enable mask
// - rising filter catches 0-to-1, falling catches 1-to-0, both allowed
// - filters read and write; clear-status leaves them alone
// - preset clears events and enables, rising all ones, falling zero
// - message available bit 4 set while output buffer holds data
// - message available clears once the output buffer is drained
// - clearing a group's event register clears its status byte summary
// - bits 0,1 zero; bit 2 error queue; bit 5 standard events
// - bit 3 summarises questionable events, bit 7 operation events
// - bit 6 set when any enabled status byte bit is set
// - standard event mask 0..255 selects bit 5 sources, kept by clear-status
// - clear-status also empties error queue and cancels completion request
module status_reporting_model #(
    parameter int WIDTH = status_pkg::GROUP_WIDTH
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CMD_VALID,
    input wire logic [status_pkg::CMD_OP_WIDTH-1:0] CMD_OP,
    input wire logic CMD_GROUP,
    input wire logic [WIDTH-1:0] CMD_DATA,
    output logic RSP_VALID,
    output logic [WIDTH-1:0] RSP_DATA,
    input wire logic [WIDTH-1:0] QUES_COND,
    input wire logic [WIDTH-1:0] OPER_COND,
    input wire logic [7:0] STD_EVENT_SET,
    input wire logic ERROR_QUEUE_NONEMPTY,
    input wire logic OUTPUT_BUFFER_NONEMPTY,
    output logic [7:0] SUMMARY_STATUS_BYTE,
    output logic SERVICE_REQUEST_SIGNAL,
    output logic ERROR_QUEUE_CLEAR,
    output logic OPC_CANCEL
);

    // elaboration check: preset constants are 16 bits wide
    if (WIDTH != status_pkg::GROUP_WIDTH) begin : g_width_check
        $error("status_reporting_model: WIDTH must equal the group width");
    end

    ////////////////////////////////////////////////////////////////////////////
    // command decode

    status_pkg::cmd_op_t op;
    logic is_clrst;
    logic is_preset;
    logic is_poll;

    // decoded strobes for the commands with side effects
    assign op = status_pkg::cmd_op_t'(CMD_OP);
    assign is_clrst = CMD_VALID && (op == status_pkg::OP_CLRST);
    assign is_preset = CMD_VALID && (op == status_pkg::OP_PRESET);
    assign is_poll = CMD_VALID && (op == status_pkg::OP_POLL);

    // summary of enabled event bits of one group
    function automatic logic summarise(input logic [WIDTH-1:0] ev,
                                       input logic [WIDTH-1:0] en);
        summarise = |(ev & en);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register groups

    logic [WIDTH-1:0] cond [status_pkg::NUM_GROUPS];
    logic [WIDTH-1:0] cond_prev_reg [status_pkg::NUM_GROUPS];
    logic [WIDTH-1:0] ev_reg [status_pkg::NUM_GROUPS];
    logic [WIDTH-1:0] ev_next [status_pkg::NUM_GROUPS];
    logic [WIDTH-1:0] en_reg [status_pkg::NUM_GROUPS];
    logic [WIDTH-1:0] en_next [status_pkg::NUM_GROUPS];
    logic [WIDTH-1:0] rise_reg [status_pkg::NUM_GROUPS];
    logic [WIDTH-1:0] rise_next [status_pkg::NUM_GROUPS];
    logic [WIDTH-1:0] fall_reg [status_pkg::NUM_GROUPS];
    logic [WIDTH-1:0] fall_next [status_pkg::NUM_GROUPS];
    logic [WIDTH-1:0] set_vec [status_pkg::NUM_GROUPS];

    // live conditions, never latched
    assign cond[status_pkg::GRP_QUES] = QUES_COND;
    assign cond[status_pkg::GRP_OPER] = OPER_COND;

    // filters, event latches and enable masks of each group
    always_comb begin
        for (int g = 0; g < status_pkg::NUM_GROUPS; g++) begin
            logic sel;
            logic ev_clr;
            sel = CMD_VALID && (int'(CMD_GROUP) == g);
            // transition filters on both edges
            set_vec[g] = (cond[g] & ~cond_prev_reg[g] & rise_reg[g])
                       | (~cond[g] & cond_prev_reg[g] & fall_reg[g]);
            ev_clr = is_clrst || is_preset
                   || (sel && op == status_pkg::OP_EVEN_RD);
            // set wins over clear; set bits just stay set
            ev_next[g] = (ev_clr ? status_pkg::EVENT_CLEAR : ev_reg[g]) | set_vec[g];
            en_next[g] = en_reg[g];
            rise_next[g] = rise_reg[g];
            fall_next[g] = fall_reg[g];
            if (is_preset) begin
                en_next[g] = status_pkg::ENAB_PRESET;
                rise_next[g] = status_pkg::RISE_PRESET;
                fall_next[g] = status_pkg::FALL_PRESET;
            end else if (sel && op == status_pkg::OP_ENAB_WR) begin
                en_next[g] = CMD_DATA;
            end else if (sel && op == status_pkg::OP_RISE_WR) begin
                rise_next[g] = CMD_DATA;
            end else if (sel && op == status_pkg::OP_FALL_WR) begin
                fall_next[g] = CMD_DATA;
            end
        end
    end

    // group state, reset to the preset state
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int g = 0; g < status_pkg::NUM_GROUPS; g++) begin
                cond_prev_reg[g] <= status_pkg::EVENT_CLEAR;
                ev_reg[g] <= status_pkg::EVENT_CLEAR;
                en_reg[g] <= status_pkg::ENAB_PRESET;
                rise_reg[g] <= status_pkg::RISE_PRESET;
                fall_reg[g] <= status_pkg::FALL_PRESET;
            end
        end else begin
            for (int g = 0; g < status_pkg::NUM_GROUPS; g++) begin
                cond_prev_reg[g] <= cond[g];
                ev_reg[g] <= ev_next[g];
                en_reg[g] <= en_next[g];
                rise_reg[g] <= rise_next[g];
                fall_reg[g] <= fall_next[g];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // standard event register, masks, status byte and service request

    logic [7:0] std_ev_reg;
    logic [7:0] std_ev_next;
    logic [7:0] semask_reg;
    logic [7:0] semask_next;
    logic [7:0] srmask_reg;
    logic [7:0] srmask_next;
    logic [7:0] sbyte_comb;
    logic [7:0] sbyte_reg;
    logic [7:0] mss_mask;
    logic [7:0] req_bits;
    logic [7:0] req_prev_reg;
    logic srq_reg;
    logic srq_next;

    // bit 6 never feeds itself
    assign mss_mask = srmask_reg & ~(8'h01 << status_pkg::SBYTE_BIT_MSS);

    // status byte condition from present state
    always_comb begin
        sbyte_comb = status_pkg::SBYTE_RESET; // bits 0 and 1 stay zero
        sbyte_comb[status_pkg::SBYTE_BIT_ERRQ] = ERROR_QUEUE_NONEMPTY;
        sbyte_comb[status_pkg::SBYTE_BIT_QUES] = summarise(ev_reg[status_pkg::GRP_QUES],
            en_reg[status_pkg::GRP_QUES]);
        sbyte_comb[status_pkg::SBYTE_BIT_MAV] = OUTPUT_BUFFER_NONEMPTY;
        sbyte_comb[status_pkg::SBYTE_BIT_ESB] = |(std_ev_reg & semask_reg);
        sbyte_comb[status_pkg::SBYTE_BIT_OPER] = summarise(ev_reg[status_pkg::GRP_OPER],
            en_reg[status_pkg::GRP_OPER]);
        sbyte_comb[status_pkg::SBYTE_BIT_MSS] = |(sbyte_comb & mss_mask);
        req_bits = sbyte_comb & mss_mask;
    end

    // standard events, masks and the request latch
    always_comb begin
        std_ev_next = ((is_clrst || (CMD_VALID && op == status_pkg::OP_ESR_RD))
                      ? status_pkg::MASK8_RESET : std_ev_reg) | STD_EVENT_SET;
        semask_next = semask_reg; // clear-status keeps it
        srmask_next = srmask_reg;
        if (CMD_VALID && op == status_pkg::OP_SEMASK_WR) begin
            semask_next = CMD_DATA[7:0];
        end
        if (CMD_VALID && op == status_pkg::OP_SRMASK_WR) begin
            srmask_next = CMD_DATA[7:0];
        end
        // request on any masked rising bit; poll clears, new rise wins
        srq_next = (srq_reg && !is_poll) || (|(req_bits & ~req_prev_reg));
    end

    // summary state registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            std_ev_reg <= status_pkg::MASK8_RESET;
            semask_reg <= status_pkg::MASK8_RESET;
            srmask_reg <= status_pkg::MASK8_RESET;
            sbyte_reg <= status_pkg::SBYTE_RESET;
            req_prev_reg <= status_pkg::MASK8_RESET;
            srq_reg <= 1'b0;
        end else begin
            std_ev_reg <= std_ev_next;
            semask_reg <= semask_next;
            srmask_reg <= srmask_next;
            sbyte_reg <= sbyte_comb;
            req_prev_reg <= req_bits;
            srq_reg <= srq_next;
        end
    end

    assign SUMMARY_STATUS_BYTE = sbyte_reg;
    assign SERVICE_REQUEST_SIGNAL = srq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // query answers and clear-status side pulses

    logic rsp_valid_reg;
    logic rsp_valid_next;
    logic [WIDTH-1:0] rsp_data_reg;
    logic [WIDTH-1:0] rsp_data_next;
    logic side_pulse_reg;

    // answer mux, one cycle after the command
    always_comb begin
        int g;
        g = int'(CMD_GROUP);
        rsp_valid_next = 1'b0;
        rsp_data_next = '0;
        if (CMD_VALID) begin
            rsp_valid_next = 1'b1;
            unique case (op)
                status_pkg::OP_SRMASK_RD: rsp_data_next = {8'h00, srmask_reg};
                status_pkg::OP_SBYTE_RD: rsp_data_next = {8'h00, sbyte_comb};
                status_pkg::OP_POLL: rsp_data_next = {8'h00, sbyte_comb};
                status_pkg::OP_SEMASK_RD: rsp_data_next = {8'h00, semask_reg};
                status_pkg::OP_ESR_RD: rsp_data_next = {8'h00, std_ev_reg};
                status_pkg::OP_EVEN_RD: rsp_data_next = ev_reg[g];
                status_pkg::OP_COND_RD: rsp_data_next = cond[g];
                status_pkg::OP_ENAB_RD: rsp_data_next = en_reg[g];
                status_pkg::OP_RISE_RD: rsp_data_next = rise_reg[g];
                status_pkg::OP_FALL_RD: rsp_data_next = fall_reg[g];
                status_pkg::OP_SRMASK_WR, status_pkg::OP_SEMASK_WR, status_pkg::OP_CLRST,
                status_pkg::OP_PRESET, status_pkg::OP_ENAB_WR, status_pkg::OP_RISE_WR,
                status_pkg::OP_FALL_WR: rsp_valid_next = 1'b0;
                default: rsp_valid_next = 1'b0; // unknown code ignored
            endcase
        end
    end

    // answer and pulse registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= '0;
            side_pulse_reg <= 1'b0;
        end else begin
            rsp_valid_reg <= rsp_valid_next;
            rsp_data_reg <= rsp_data_next;
            side_pulse_reg <= is_clrst;
        end
    end

    assign RSP_VALID = rsp_valid_reg;
    assign RSP_DATA = rsp_data_reg;
    assign ERROR_QUEUE_CLEAR = side_pulse_reg;
    assign OPC_CANCEL = side_pulse_reg;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    AST_MSS_FROM_MASK: assert property (
        SUMMARY_STATUS_BYTE[status_pkg::SBYTE_BIT_MSS]
            == |(SUMMARY_STATUS_BYTE & $past(mss_mask)))
        else $error("master summary does not match masked status byte");
    AST_LOW_BITS_ZERO: assert property (
        SUMMARY_STATUS_BYTE[1:0] == 2'b00)
        else $error("status byte bits 0 and 1 not zero");
    AST_SRQ_ON_RISE: assert property (
        |(req_bits & ~req_prev_reg) |=> SERVICE_REQUEST_SIGNAL)
        else $error("masked rising status bit gave no service request");
    AST_STB_KEEPS_SRQ: assert property (
        CMD_VALID && op == status_pkg::OP_SBYTE_RD && srq_reg
            |=> SERVICE_REQUEST_SIGNAL && RSP_VALID && RSP_DATA[7:0] == SUMMARY_STATUS_BYTE)
        else $error("status byte query altered request or answered wrong");
    AST_EVENT_HOLDS: assert property (
        !is_clrst && !is_preset && !(CMD_VALID && op == status_pkg::OP_EVEN_RD
            && CMD_GROUP == 1'b0)
            |=> (ev_reg[0] & $past(ev_reg[0])) == $past(ev_reg[0]))
        else $error("questionable event bit dropped without a clear");
    AST_RISE_SETS_EVENT: assert property (
        ##1 ((ev_reg[0] & $past(set_vec[0])) == $past(set_vec[0])))
        else $error("filtered condition change did not set event bit");
    AST_CLS_CLEARS: assert property (
        is_clrst |=> (ev_reg[1] & ~$past(set_vec[1])) == '0 && $stable(en_reg[1])
            && $stable(rise_reg[1]) && $stable(semask_reg))
        else $error("clear-status cleared too little or too much");
    AST_PRESET_VALUES: assert property (
        is_preset |=> rise_reg[0] == status_pkg::RISE_PRESET
            && fall_reg[1] == status_pkg::FALL_PRESET
            && en_reg[0] == status_pkg::ENAB_PRESET)
        else $error("preset left wrong filter or enable values");
    AST_MAV_FOLLOWS: assert property (
        OUTPUT_BUFFER_NONEMPTY |=> SUMMARY_STATUS_BYTE[status_pkg::SBYTE_BIT_MAV])
        else $error("message available not raised");
    AST_MAV_CLEARS: assert property (
        !OUTPUT_BUFFER_NONEMPTY |=> !SUMMARY_STATUS_BYTE[status_pkg::SBYTE_BIT_MAV])
        else $error("message available not cleared");
    AST_CLS_SIDE: assert property (
        is_clrst |=> ERROR_QUEUE_CLEAR && OPC_CANCEL ##1 !ERROR_QUEUE_CLEAR || is_clrst)
        else $error("clear-status side pulses wrong");
    // a poll with no fresh masked rise drops the request
    AST_POLL_CLEARS_SRQ: assert property (
        is_poll && !(|(req_bits & ~req_prev_reg)) |=> !SERVICE_REQUEST_SIGNAL)
        else $error("serial poll left the service request standing");
    // mask read answers the stored mask, zero extended
    AST_SRMASK_READBACK: assert property (
        CMD_VALID && op == status_pkg::OP_SRMASK_RD
            |=> RSP_VALID && RSP_DATA == {8'h00, $past(srmask_reg)})
        else $error("service request mask read back wrong");
    // an enable write never produces an answer
    AST_NO_ANSWER_ON_WRITE: assert property (
        CMD_VALID && op == status_pkg::OP_ENAB_WR |=> !RSP_VALID)
        else $error("enable write produced an answer");

    COV_SRQ: cover property (!srq_reg ##1 srq_reg ##[1:20] is_poll);
    COV_PRESET: cover property (is_preset);
    COV_EVEN_RD: cover property (CMD_VALID && op == status_pkg::OP_EVEN_RD && ev_reg[0] != '0);
    COV_FALL: cover property (|(~cond[1] & cond_prev_reg[1] & fall_reg[1]));

endmodule

`default_nettype wire

// ===== verification/status_host_model.sv
/*
 * host side model: issues decoded status commands and queries, one at a time.
 * assumes the clock is shared with the status block and that commands are
 * sampled on the rising edge; this model changes its outputs on falling edges.
 */
`timescale 1ns/1ps
`default_nettype none

module status_host_model (
    input wire logic clk,
    output logic cmd_valid,
    output logic [status_pkg::CMD_OP_WIDTH-1:0] cmd_op,
    output logic cmd_group,
    output logic [15:0] cmd_data
);

    ////////////////////////////////////////////////////////////////////////////
    // idle values at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_op = 5'h00;
        cmd_group = 1'b0;
        cmd_data = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one command: strobe for a single cycle, then scramble the idle lines
    task automatic issue(input logic [4:0] op, input logic grp, input logic [15:0] data);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_group = grp;
        cmd_data = data;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_op = ~op; // idle lines never keep a stale but plausible value
        cmd_data = ~data;
        cmd_group = ~grp;
    endtask

endmodule

`default_nettype wire

// ===== verification/status_reporting_model_tb.sv
/*
 * self-checking bench of the status reporting block: a host model issues
 * commands, answers are matched against a queue of expected values.
 * assumes the status package and both design files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module status_reporting_model_tb;

    logic clk;
    logic rst_n;
    logic cmd_valid;
    logic [4:0] cmd_op;
    logic cmd_group;
    logic [15:0] cmd_data;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic [15:0] ques_cond;
    logic [15:0] oper_cond;
    logic [7:0] std_event_set;
    logic err_q_nonempty;
    logic out_buf_nonempty;
    logic [7:0] sbyte;
    logic srq;
    logic err_q_clear;
    logic opc_cancel;
    logic [15:0] exp_q[$];
    logic [15:0] p, n, c;
    int mismatches;
    int checks;

    ////////////////////////////////////////////////////////////////////////////
    // instances
    status_reporting_model status_reporting_model_inst (
        .CLK(clk), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
        .CMD_GROUP(cmd_group), .CMD_DATA(cmd_data), .RSP_VALID(rsp_valid),
        .RSP_DATA(rsp_data), .QUES_COND(ques_cond), .OPER_COND(oper_cond),
        .STD_EVENT_SET(std_event_set), .ERROR_QUEUE_NONEMPTY(err_q_nonempty),
        .OUTPUT_BUFFER_NONEMPTY(out_buf_nonempty), .SUMMARY_STATUS_BYTE(sbyte),
        .SERVICE_REQUEST_SIGNAL(srq), .ERROR_QUEUE_CLEAR(err_q_clear),
        .OPC_CANCEL(opc_cancel)
    );
    status_host_model status_host_model_inst (
        .clk(clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_group(cmd_group), .cmd_data(cmd_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock, 100 MHz
    initial clk = 1'b0;
    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic rd(input logic [4:0] op, input logic grp, input logic [15:0] exp);
        exp_q.push_back(exp);
        status_host_model_inst.issue(op, grp, 16'h0000);
    endtask

    task automatic wr(input logic [4:0] op, input logic grp, input logic [15:0] data);
        status_host_model_inst.issue(op, grp, data);
    endtask

    task automatic setc(input logic grp, input logic [15:0] v);
        if (grp == 1'b0) begin
            ques_cond = v;
        end else begin
            oper_cond = v;
        end
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // answer watcher: every answer takes the oldest expectation
    always @(negedge clk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                mismatches++;
                $display("Error at %0t ns: answer with none expected", $time);
            end else begin
                chk(rsp_data, exp_q.pop_front());
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the roughly 120 cycles the tests need
    initial begin
        #100000;
        mismatches++;
        $display("Error at %0t ns: watchdog expired", $time);
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        mismatches = 0;
        checks = 0;
        rst_n = 1'b0;
        ques_cond = 16'h0000;
        oper_cond = 16'h0000;
        std_event_set = 8'h00;
        err_q_nonempty = 1'b0;
        out_buf_nonempty = 1'b0;
        void'($urandom(32));
        cyc(3);
        rst_n = 1'b1;
        // reset state of every group and the service request mask
        for (int g = 0; g < 2; g++) begin
            rd(status_pkg::OP_RISE_RD, g[0], 16'hffff);
            rd(status_pkg::OP_FALL_RD, g[0], 16'h0000);
            rd(status_pkg::OP_ENAB_RD, g[0], 16'h0000);
            rd(status_pkg::OP_EVEN_RD, g[0], 16'h0000);
        end
        rd(status_pkg::OP_SRMASK_RD, 1'b0, 16'h0000);
        // random filters and a condition pulse in each group
        for (int g = 0; g < 2; g++) begin
            p = 16'($urandom);
            n = 16'($urandom);
            c = 16'($urandom);
            wr(status_pkg::OP_RISE_WR, g[0], p);
            wr(status_pkg::OP_FALL_WR, g[0], n);
            rd(status_pkg::OP_RISE_RD, g[0], p);
            rd(status_pkg::OP_FALL_RD, g[0], n);
            setc(g[0], c);
            cyc(2);
            rd(status_pkg::OP_COND_RD, g[0], c);
            rd(status_pkg::OP_COND_RD, g[0], c);
            setc(g[0], 16'h0000);
            cyc(2);
            rd(status_pkg::OP_EVEN_RD, g[0], c & (p | n));
            rd(status_pkg::OP_EVEN_RD, g[0], 16'h0000);
        end
        // summary bits, master summary and the service request
        wr(status_pkg::OP_RISE_WR, 1'b0, 16'h0001);
        wr(status_pkg::OP_ENAB_WR, 1'b0, 16'h0001);
        wr(status_pkg::OP_SRMASK_WR, 1'b0, 16'h0088);
        rd(status_pkg::OP_SRMASK_RD, 1'b0, 16'h0088);
        chk({15'h0, srq}, 16'h0000);
        ques_cond = 16'h0001;
        cyc(3);
        chk({15'h0, sbyte[3]}, 16'h0001);
        chk({15'h0, srq}, 16'h0001);
        rd(status_pkg::OP_SBYTE_RD, 1'b0, 16'h0048);
        chk({15'h0, srq}, 16'h0001);
        rd(status_pkg::OP_POLL, 1'b0, 16'h0048);
        cyc(1);
        chk({15'h0, srq}, 16'h0000);
        wr(status_pkg::OP_RISE_WR, 1'b1, 16'h0100);
        wr(status_pkg::OP_ENAB_WR, 1'b1, 16'h0100);
        oper_cond = 16'h0100;
        cyc(3);
        chk({15'h0, sbyte[7]}, 16'h0001);
        chk({15'h0, srq}, 16'h0001);
        // clear-status: events go, masks and filters stay, pulses out
        wr(status_pkg::OP_CLRST, 1'b0, 16'h0000);
        chk({14'h0, err_q_clear, opc_cancel}, 16'h0003);
        cyc(2);
        chk({8'h00, sbyte & 8'h88}, 16'h0000);
        rd(status_pkg::OP_EVEN_RD, 1'b1, 16'h0000);
        rd(status_pkg::OP_ENAB_RD, 1'b0, 16'h0001);
        rd(status_pkg::OP_RISE_RD, 1'b0, 16'h0001);
        // error queue, message available, standard events
        wr(status_pkg::OP_SEMASK_WR, 1'b0, 16'h0004);
        std_event_set = 8'h04;
        cyc(1);
        std_event_set = 8'h00;
        err_q_nonempty = 1'b1;
        out_buf_nonempty = 1'b1;
        cyc(3);
        chk({8'h00, sbyte}, 16'h0034);
        rd(status_pkg::OP_SEMASK_RD, 1'b0, 16'h0004);
        rd(status_pkg::OP_ESR_RD, 1'b0, 16'h0004);
        out_buf_nonempty = 1'b0;
        cyc(3);
        chk({8'h00, sbyte}, 16'h0004);
        // unknown code gives no answer; the watcher flags any
        wr(5'h1f, 1'b0, 16'hffff);
        // preset
        wr(status_pkg::OP_PRESET, 1'b0, 16'h0000);
        rd(status_pkg::OP_ENAB_RD, 1'b1, 16'h0000);
        rd(status_pkg::OP_RISE_RD, 1'b0, 16'hffff);
        rd(status_pkg::OP_FALL_RD, 1'b0, 16'h0000);
        cyc(3);
        chk(16'(exp_q.size()), 16'h0000);
        print_verdict();
    end

endmodule

`default_nettype wire
